// [core/zosc_defines.vh]
// Contract
// - Reset clears program counter to zero.
// - Three stack registers, no reset value.
// - No status word or carry flag.
// - Datapath, data and addresses sixteen bits.
// - Opcodes zero through seven do nothing.
// - Opcode eight pushes word at counter.
// - Opcode nine replaces head with memory.
// - Opcode A stores second; all become third.
// - Opcode B adds second to head.
// - Opcode C ands second into head.
// - Opcode D ors second into head.
// - Opcode E xors second into head.
// - Opcode F jumps to head if second zero.
// - Shrinking stack keeps third, refills from it.
// - Only push deepens stack, dropping third.
// - Every opcode completes in one clock.
// - Group fetch after group end or jump.
// - Straight-line group takes five clocks total.
// - Program counter addresses whole instruction groups.
`ifndef ZOSC_DEFINES_VH
`define ZOSC_DEFINES_VH

`define ZOSC_DATA_W 16
`define ZOSC_RESET_PC 16'h0000
`define ZOSC_SLOT_LAST 2'h3

// Sequencer states.
`define ZOSC_ST_FETCH 1'b0
`define ZOSC_ST_EXEC 1'b1

// Opcodes; 0 to 7 are all idle.
`define ZOSC_OP_LIT 4'h8
`define ZOSC_OP_LOAD 4'h9
`define ZOSC_OP_STORE 4'ha
`define ZOSC_OP_ADD 4'hb
`define ZOSC_OP_AND 4'hc
`define ZOSC_OP_OR 4'hd
`define ZOSC_OP_XOR 4'he
`define ZOSC_OP_BRZ 4'hf

// Stack update selects.
`define ZOSC_STK_HOLD 3'h0
`define ZOSC_STK_PUSH 3'h1
`define ZOSC_STK_HEAD 3'h2
`define ZOSC_STK_BIN 3'h3
`define ZOSC_STK_FLUSH 3'h4

`endif

// [core/zosc_alu.v]
`timescale 1ns/1ps
`include "zosc_defines.vh"

// ****************************************************************
// Two-operand logic and arithmetic unit
// ****************************************************************
module zosc_alu #(
    parameter W = `ZOSC_DATA_W
) (
    input wire [3:0] i_op,
    input wire [W-1:0] i_second,
    input wire [W-1:0] i_head,
    output reg [W-1:0] o_result
);

    // No carry is kept anywhere; the sum simply wraps.
    // no carry flag
    always @*
    begin
        case (i_op)
            `ZOSC_OP_ADD: o_result = i_second + i_head;
            `ZOSC_OP_AND: o_result = i_second & i_head;
            `ZOSC_OP_OR: o_result = i_second | i_head;
            `ZOSC_OP_XOR: o_result = i_second ^ i_head;
            default: o_result = i_head;
        endcase
    end

endmodule // zosc_alu

// [core/zosc_stack.v]
`timescale 1ns/1ps
`include "zosc_defines.vh"

// ****************************************************************
// Three-entry evaluation stack
// ****************************************************************
module zosc_stack #(
    parameter W = `ZOSC_DATA_W
) (
    input wire i_core_clk,
    input wire [2:0] i_ctl,
    input wire [W-1:0] i_mem_data,
    input wire [W-1:0] i_alu_data,
    output wire [W-1:0] o_head,
    output wire [W-1:0] o_second,
    output wire [W-1:0] o_third,
    output reg [W-1:0] o_nxt_head,
    output reg [W-1:0] o_nxt_second
);

    reg [W-1:0] head_ff;
    reg [W-1:0] second_ff;
    reg [W-1:0] third_ff;
    reg [W-1:0] nxt_third;

    assign o_head = head_ff;
    assign o_second = second_ff;
    assign o_third = third_ff;

    always @*
    begin
        o_nxt_head = head_ff;
        o_nxt_second = second_ff;
        nxt_third = third_ff;
        case (i_ctl)
            `ZOSC_STK_PUSH:
            begin
                o_nxt_head = i_mem_data;
                o_nxt_second = head_ff;
                nxt_third = second_ff;
            end
            `ZOSC_STK_HEAD: o_nxt_head = i_mem_data;
            `ZOSC_STK_BIN:
            begin
                o_nxt_head = i_alu_data;
                o_nxt_second = third_ff;
            end
            `ZOSC_STK_FLUSH:
            begin
                o_nxt_head = third_ff;
                o_nxt_second = third_ff;
            end
            default:
            begin
                o_nxt_head = head_ff;
            end
        endcase
    end

    // Data registers carry no reset: software must load them before use,
    // and leaving reset off saves the mux on every entry.
    // unreset stack entries
    always @(posedge i_core_clk)
    begin
        head_ff <= o_nxt_head;
        second_ff <= o_nxt_second;
        third_ff <= nxt_third;
    end

endmodule // zosc_stack

// [core/zosc_core.v]
`timescale 1ns/1ps
`include "zosc_defines.vh"

// ****************************************************************
// Zero-operand stack processor core
// ****************************************************************
module zosc_core #(
    parameter W = `ZOSC_DATA_W
) (
    input wire i_core_clk,
    input wire i_rst,
    input wire [W-1:0] i_mem_rdata,
    output wire [W-1:0] o_mem_addr,
    output wire [W-1:0] o_mem_wdata,
    output wire o_mem_we,
    output wire o_mem_rd,
    output wire o_group_fetch,
    output wire [W-1:0] o_pc,
    output wire [3:0] o_opcode,
    output wire o_branch_taken,
    output wire [W-1:0] o_head,
    output wire [W-1:0] o_second,
    output wire [W-1:0] o_third
);

    // ****************************************************************
    // State encoding
    // ****************************************************************
    // Two states are enough: every opcode finishes in its own cycle, so the
    // sequencer only has to tell a group fetch from an execute slot.
    localparam ST_FETCH = `ZOSC_ST_FETCH;
    localparam ST_EXEC = `ZOSC_ST_EXEC;

    // ****************************************************************
    // Registers and wires
    // ****************************************************************
    reg state_ff;
    reg nxt_state;
    reg [W-1:0] ir_ff;
    reg [W-1:0] nxt_ir;
    reg [1:0] slot_ff;
    reg [1:0] nxt_slot;
    reg [W-1:0] pc_ff;
    reg [W-1:0] nxt_pc;
    reg [W-1:0] addr_ff;
    reg [W-1:0] nxt_addr;
    reg [W-1:0] wdata_ff;
    reg [W-1:0] nxt_wdata;
    reg we_ff;
    reg nxt_we;
    reg rd_ff;
    reg nxt_rd;
    reg gf_ff;
    reg nxt_gf;
    reg [3:0] op_ff;
    reg taken_ff;
    reg nxt_taken;
    reg [2:0] stk_ctl;

    wire [3:0] cur_op;
    wire [3:0] nxt_op;
    wire [W-1:0] head;
    wire [W-1:0] second;
    wire [W-1:0] third;
    wire [W-1:0] nxt_head;
    wire [W-1:0] nxt_second;
    wire [W-1:0] alu_result;

    // ****************************************************************
    // Opcode selection
    // ****************************************************************
    // high nibble first
    function [3:0] nibble_at;
        input [15:0] group;
        input [1:0] slot;
        begin
            case (slot)
                2'h0: nibble_at = group[15:12];
                2'h1: nibble_at = group[11:8];
                2'h2: nibble_at = group[7:4];
                default: nibble_at = group[3:0];
            endcase
        end
    endfunction

    assign cur_op = nibble_at(ir_ff, slot_ff);
    assign nxt_op = nibble_at(nxt_ir, nxt_slot);

    // ****************************************************************
    // Arithmetic unit
    // ****************************************************************
    // sixteen-bit datapath
    zosc_alu #(
        .W(W)
    ) u_alu (
        .i_op(cur_op),
        .i_second(second),
        .i_head(head),
        .o_result(alu_result)
    );

    // ****************************************************************
    // Evaluation stack
    // ****************************************************************
    zosc_stack #(
        .W(W)
    ) u_stack (
        .i_core_clk(i_core_clk),
        .i_ctl(stk_ctl),
        .i_mem_data(i_mem_rdata),
        .i_alu_data(alu_result),
        .o_head(head),
        .o_second(second),
        .o_third(third),
        .o_nxt_head(nxt_head),
        .o_nxt_second(nxt_second)
    );

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    // The memory answers in the cycle its address is shown, so the read
    // data is consumed by whatever step the current state describes.
    always @*
    begin
        nxt_state = state_ff;
        nxt_ir = ir_ff;
        nxt_slot = slot_ff;
        nxt_pc = pc_ff;
        nxt_taken = 1'b0;
        stk_ctl = `ZOSC_STK_HOLD;
        case (state_ff)
            ST_FETCH:
            begin
                nxt_ir = i_mem_rdata;
                nxt_pc = pc_ff + 16'h0001;
                nxt_slot = 2'h0;
                nxt_state = ST_EXEC;
            end
            ST_EXEC:
            begin
                case (cur_op)
                    // The inline word sits right after the group, so the
                    // counter already points at it when the push executes.
                    // push inline word
                    `ZOSC_OP_LIT:
                    begin
                        stk_ctl = `ZOSC_STK_PUSH;
                        nxt_pc = pc_ff + 16'h0001;
                    end
                    `ZOSC_OP_LOAD: stk_ctl = `ZOSC_STK_HEAD;
                    `ZOSC_OP_STORE: stk_ctl = `ZOSC_STK_FLUSH;
                    `ZOSC_OP_ADD: stk_ctl = `ZOSC_STK_BIN;
                    `ZOSC_OP_AND: stk_ctl = `ZOSC_STK_BIN;
                    `ZOSC_OP_OR: stk_ctl = `ZOSC_STK_BIN;
                    `ZOSC_OP_XOR: stk_ctl = `ZOSC_STK_BIN;
                    `ZOSC_OP_BRZ:
                    begin
                        stk_ctl = `ZOSC_STK_FLUSH;
                        nxt_taken = (second == 16'h0000);
                    end
                    default: stk_ctl = `ZOSC_STK_HOLD;
                endcase
                if (nxt_taken)
                begin
                    nxt_pc = head;
                    nxt_state = ST_FETCH;
                end
                // Trailing no-ops keep their slots, so group timing only changes when
                // an opcode F jump is taken and ends the group early.
                // four slots then fetch
                else if (slot_ff == `ZOSC_SLOT_LAST)
                begin
                    nxt_state = ST_FETCH;
                end
                else
                begin
                    nxt_slot = slot_ff + 2'h1;
                end
            end
        endcase
    end

    // ****************************************************************
    // Bus request for the next cycle
    // ****************************************************************
    // Bus outputs are registered, so the request is worked out one cycle
    // ahead from the next state. This lengthens the read-data path into
    // the address but keeps every pin on a flip-flop.
    always @*
    begin
        nxt_addr = addr_ff;
        nxt_wdata = wdata_ff;
        nxt_we = 1'b0;
        nxt_rd = 1'b0;
        nxt_gf = 1'b0;
        if (nxt_state == ST_FETCH)
        begin
            nxt_addr = nxt_pc;
            nxt_rd = 1'b1;
            nxt_gf = 1'b1;
        end
        else if (nxt_op == `ZOSC_OP_LIT)
        begin
            nxt_addr = nxt_pc;
            nxt_rd = 1'b1;
        end
        else if (nxt_op == `ZOSC_OP_LOAD)
        begin
            nxt_addr = nxt_head;
            nxt_rd = 1'b1;
        end
        else if (nxt_op == `ZOSC_OP_STORE)
        begin
            nxt_addr = nxt_head;
            nxt_wdata = nxt_second;
            nxt_we = 1'b1;
        end
    end

    // ****************************************************************
    // Sequencer registers
    // ****************************************************************
    always @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            state_ff <= ST_FETCH;
            ir_ff <= 16'h0000;
            slot_ff <= 2'h0;
            pc_ff <= `ZOSC_RESET_PC;
        end
        else
        begin
            state_ff <= nxt_state;
            ir_ff <= nxt_ir;
            slot_ff <= nxt_slot;
            pc_ff <= nxt_pc;
        end
    end

    // ****************************************************************
    // Memory bus registers
    // ****************************************************************
    // Reset leaves a read of address zero on the bus, so the first group
    // is already being fetched in the cycle after reset is released.
    always @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            addr_ff <= `ZOSC_RESET_PC;
            wdata_ff <= 16'h0000;
            we_ff <= 1'b0;
            rd_ff <= 1'b1;
            gf_ff <= 1'b1;
        end
        else
        begin
            addr_ff <= nxt_addr;
            wdata_ff <= nxt_wdata;
            we_ff <= nxt_we;
            rd_ff <= nxt_rd;
            gf_ff <= nxt_gf;
        end
    end

    // ****************************************************************
    // Execution report registers
    // ****************************************************************
    always @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            op_ff <= 4'h0;
            taken_ff <= 1'b0;
        end
        else
        begin
            // A fetch cycle reports opcode zero, so a watcher never sees a stale slot.
            op_ff <= (nxt_state == ST_EXEC) ? nxt_op : 4'h0;
            taken_ff <= nxt_taken;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign o_mem_addr = addr_ff;
    assign o_mem_wdata = wdata_ff;
    assign o_mem_we = we_ff;
    assign o_mem_rd = rd_ff;
    assign o_group_fetch = gf_ff;
    assign o_pc = pc_ff;
    assign o_opcode = op_ff;
    assign o_branch_taken = taken_ff;
    assign o_head = head;
    assign o_second = second;
    assign o_third = third;

endmodule // zosc_core

// [tb/zosc_core_asserts.sv]
`timescale 1ns/1ps
// ****
// Core port checker
// ****
module zosc_core_asserts #(
    parameter W = 16
) (
    input wire i_core_clk,
    input wire i_rst,
    input wire [W-1:0] i_mem_rdata,
    input wire [W-1:0] o_mem_addr,
    input wire [W-1:0] o_mem_wdata,
    input wire o_mem_we,
    input wire o_mem_rd,
    input wire o_group_fetch,
    input wire [3:0] o_opcode,
    input wire o_branch_taken,
    input wire [W-1:0] o_head,
    input wire [W-1:0] o_second,
    input wire [W-1:0] o_third
);
    reg [W-1:0] alu_exp;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);
    always @*
    begin
        case (o_opcode)
            4'hb: alu_exp = o_second + o_head;
            4'hc: alu_exp = o_second & o_head;
            4'hd: alu_exp = o_second | o_head;
            default: alu_exp = o_second ^ o_head;
        endcase
    end
    sequence s_straight_group;
        o_group_fetch ##1 (!o_group_fetch && o_opcode != 4'hf) [*4];
    endsequence
    sequence s_taken_branch;
        !o_group_fetch && o_opcode == 4'hf && o_second == 16'h0000;
    endsequence
    chk_five_clocks: assert property (s_straight_group |=> o_group_fetch)
        else $error("group time wrong");
    chk_fetch_cycle: assert property (o_group_fetch |-> o_mem_rd && !o_mem_we ##1 !o_group_fetch)
        else $error("fetch cycle wrong");
    chk_jump_target: assert property (s_taken_branch |=> o_branch_taken && o_group_fetch
        && o_mem_addr == $past(o_head))
        else $error("jump wrong");
    chk_store_strobe: assert property (o_mem_we == (o_opcode == 4'ha))
        else $error("strobe wrong");
    chk_store_bus: assert property (o_mem_we |-> o_mem_addr == o_head && o_mem_wdata == o_second)
        else $error("store bus wrong");
    chk_shrink_third: assert property (!o_group_fetch && o_opcode >= 4'ha
        |=> o_third == $past(o_third) && o_second == $past(o_third))
        else $error("shrink wrong");
    chk_alu_result: assert property (!o_group_fetch && o_opcode inside {[4'hb:4'he]}
        |=> o_head == $past(alu_exp))
        else $error("alu wrong");
    chk_push_word: assert property (o_opcode == 4'h8 |-> o_mem_rd ##1 o_head === $past(i_mem_rdata)
        && o_second === $past(o_head) && o_third === $past(o_second))
        else $error("push wrong");
    chk_load_word: assert property (o_opcode == 4'h9 |-> o_mem_rd && o_mem_addr == o_head
        ##1 o_head == $past(i_mem_rdata) && $stable(o_second))
        else $error("load wrong");
    chk_idle_hold: assert property (!o_group_fetch && o_opcode < 4'h8
        |=> $stable(o_head) && $stable(o_second) && $stable(o_third))
        else $error("idle wrong");
endmodule // zosc_core_asserts

bind zosc_core zosc_core_asserts #(.W(W)) u_chk (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_mem_rdata(i_mem_rdata),
    .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata),
    .o_mem_we(o_mem_we),
    .o_mem_rd(o_mem_rd),
    .o_group_fetch(o_group_fetch),
    .o_opcode(o_opcode),
    .o_branch_taken(o_branch_taken),
    .o_head(o_head),
    .o_second(o_second),
    .o_third(o_third)
);

// [tb/zosc_mem_model.sv]
`timescale 1ns/1ps
// ****
// Word memory
// ****
module zosc_mem_model (
    input wire i_core_clk,
    input wire [15:0] i_addr,
    input wire [15:0] i_wdata,
    input wire i_we,
    input wire i_rd,
    output wire [15:0] o_rdata
);
    reg [15:0] mem [0:65535];
    // same cycle answer
    // Outside reads the bus shows a spoiled value so a late sample is caught.
    assign o_rdata = i_rd ? mem[i_addr] : ~mem[i_addr];
    always @(posedge i_core_clk)
    begin
        if (i_we)
            mem[i_addr] <= i_wdata;
    end
endmodule // zosc_mem_model

// [tb/zosc_core_tb.sv]
`timescale 1ns/1ps
// ****
// Core testbench
// ****
module zosc_core_tb;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    wire [15:0] rdata, addr, wdata, head, second, third, pc;
    wire we, rd, gf, bt;
    wire [3:0] op;
    int errors = 0;
    int samples_checked = 0;
    int gap;
    logic [15:0] prog [0:22] = '{16'h888b, 16'h1111, 16'h2222, 16'h5555, 16'h8c8d, 16'h0f0f, 16'h00ff,
        16'h8e90, 16'h1234, 16'h88a1, 16'h3c3c, 16'h0040, 16'h88f0, 16'h0000, 16'h0014, 16'h8a00,
        16'h0, 16'h0, 16'h0, 16'h0, 16'h88f0, 16'h0001, 16'h0000};

    zosc_core dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_mem_rdata(rdata), .o_mem_addr(addr),
        .o_mem_wdata(wdata), .o_mem_we(we), .o_mem_rd(rd), .o_group_fetch(gf), .o_pc(pc),
        .o_opcode(op), .o_branch_taken(bt), .o_head(head), .o_second(second), .o_third(third));
    zosc_mem_model mem_m (.i_core_clk(i_core_clk), .i_addr(addr), .i_wdata(wdata), .i_we(we),
        .i_rd(rd), .o_rdata(rdata));

    initial
    begin
        forever #5 i_core_clk = ~i_core_clk;
    end

    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task end_of_test;
        if (errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // A zero spacing skips the spacing compare when the walk started mid-group.
    task next_group(input logic [15:0] a, input int n, input logic [15:0] h, s, t);
        gap = 0;
        do
        begin
            @(negedge i_core_clk);
            gap++;
        end
        while (gf !== 1'b1 && gap < 20);
        check("fetch seen", {15'h0, gf}, 16'h0001);
        check("fetch address", addr, a);
        check("group counter", pc, a);
        if (n != 0)
            check("fetch spacing", 16'(gap), 16'(n));
        check("head", head, h);
        check("second", second, s);
        check("third", third, t);
    endtask

    task test_reset;
        check("reset fetch", {15'h0, gf}, 16'h0001);
        check("reset strobe", {15'h0, we}, 16'h0000);
        check("first fetch", addr, 16'h0000);
        check("reset counter", pc, 16'h0000);
        check("reset opcode", {12'h0, op}, 16'h0000);
        i_rst = 1'b0;
    endtask

    // Reset in the middle of a group must restart the program from address zero.
    task test_mid_reset;
        @(negedge i_core_clk);
        i_rst = 1'b1;
        repeat (2) @(negedge i_core_clk);
        test_reset;
        test_arith;
    endtask

    task test_arith;
        for (int i = 0; i < 4; i++)
        begin
            @(negedge i_core_clk);
            check("opcode order", {12'h0, op}, {12'h0, prog[0][15-4*i -: 4]});
        end
        next_group(16'h0004, 0, 16'h7777, 16'h1111, 16'h1111);
        next_group(16'h0007, 5, 16'h07ff, 16'h1111, 16'h1111);
    endtask

    task test_load_store;
        next_group(16'h0009, 5, 16'ha55a, 16'h1111, 16'h1111);
        next_group(16'h000c, 5, 16'ha55a, 16'ha55a, 16'ha55a);
        check("stored word", mem_m.mem[16'h0040], 16'h3c3c);
    endtask

    task test_branch;
        next_group(16'h0014, 4, 16'ha55a, 16'ha55a, 16'ha55a);
        check("jump flag", {15'h0, bt}, 16'h0001);
        next_group(16'h0017, 5, 16'ha55a, 16'ha55a, 16'ha55a);
        check("no jump flag", {15'h0, bt}, 16'h0000);
    endtask

    initial
    begin
        repeat (500) @(posedge i_core_clk);
        errors++;
        end_of_test;
    end

    initial
    begin
        for (int i = 0; i < 65536; i++)
            mem_m.mem[i] = 16'h0000;
        for (int i = 0; i < 23; i++)
            mem_m.mem[i] = prog[i];
        mem_m.mem[16'h15cb] = 16'ha55a;
        repeat (5) @(negedge i_core_clk);
        test_reset;
        test_arith;
        test_load_store;
        test_branch;
        test_mid_reset;
        end_of_test;
    end
endmodule // zosc_core_tb
